//--- shared/tbo_pkg.sv
// Constants and types for the 10Base-T operations register block
`default_nettype none
package tbo_pkg;
	localparam int CLK_MHZ = 20;
	localparam logic [4:0] TBO_REG_ADDR = 5'h12;
	localparam int REG_W = 16;
	localparam int BIT_REMOTE_JABBER = 15;
	localparam int BIT_POL_REVERSED = 14;
	localparam int RSVD_HI = 13;
	localparam int RSVD_LO = 6;
	localparam int BIT_JABBER_INH = 5;
	localparam int BIT_RSVD_ONE = 4;
	localparam int BIT_AUTOPOL_INH = 3;
	localparam int BIT_SQE_INH = 2;
	localparam int BIT_LINKLOSS_INH = 1;
	localparam int BIT_SQUELCH_INH = 0;
	localparam logic [15:0] TBO_RESET_VALUE = 16'h0010;
	localparam logic [15:0] TBO_RW_MASK = 16'h3fff;
	localparam logic [15:0] TBO_ZERO = 16'h0000;
	// Jabber limit on transmit and receive activity, in microseconds
	localparam int JABBER_LIMIT_US = 20000;
	localparam int JABBER_LIMIT_CYCLES = JABBER_LIMIT_US * CLK_MHZ;
	// SQE test: delay after end of transmit, then pulse width
	localparam int SQE_DELAY_NS = 800;
	localparam int SQE_WIDTH_NS = 1000;
	localparam int SQE_DELAY_CYCLES = (SQE_DELAY_NS * CLK_MHZ + 999) / 1000;
	localparam int SQE_WIDTH_CYCLES = (SQE_WIDTH_NS * CLK_MHZ + 999) / 1000;
	localparam int SQE_CNT_W = 6;
	localparam int SYNC_W = 8;
	typedef enum logic [2:0] {
		LINK_FAIL = 3'b001,
		LINK_WAIT_IDLE = 3'b010,
		LINK_PASS = 3'b100
	} tbo_link_state_type;
	typedef enum logic [2:0] {
		SQE_IDLE = 3'b001,
		SQE_WAIT = 3'b010,
		SQE_PULSE = 3'b100
	} tbo_sqe_state_type;
endpackage
`default_nettype wire

//--- shared/tbo_sqe_if.sv
// Interface between the register block and its SQE test generator
`default_nettype none
interface tbo_sqe_if;
	logic tx_en;
	logic sqe_enable;
	logic sqe_col;
	modport ctrl (output tx_en, output sqe_enable, input sqe_col);
	modport gen (input tx_en, input sqe_enable, output sqe_col);
endinterface
`default_nettype wire

//--- verilog/tbo_sqe_gen.sv
// SQE test pulse generator following the end of each transmission
`default_nettype none
module tbo_sqe_gen
	import tbo_pkg::*;
(
	input wire logic core_clk, // 20 MHz clock
	input wire logic rst_n, // Async reset, active low
	tbo_sqe_if.gen sqe // Transmit enable in, collision pulse out
);
	tbo_sqe_state_type state_reg;
	logic [SQE_CNT_W-1:0] cnt_reg;
	logic tx_en_d_reg;
	logic tx_end;

	assign tx_end = tx_en_d_reg & ~sqe.tx_en;

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			tx_en_d_reg <= 1'b0;
		end else begin
			tx_en_d_reg <= sqe.tx_en;
		end
	end

	// Enable is sampled at packet end; a new packet aborts a pending test
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_reg <= SQE_IDLE;
			cnt_reg <= '0;
		end else begin
			case (state_reg)
				SQE_IDLE: begin
					if (tx_end && sqe.sqe_enable) begin
						state_reg <= SQE_WAIT;
						cnt_reg <= SQE_CNT_W'(SQE_DELAY_CYCLES - 1);
					end
				end
				SQE_WAIT: begin
					if (sqe.tx_en) begin
						state_reg <= SQE_IDLE;
					end else if (cnt_reg == '0) begin
						state_reg <= SQE_PULSE;
						cnt_reg <= SQE_CNT_W'(SQE_WIDTH_CYCLES - 1);
					end else begin
						cnt_reg <= cnt_reg - 1'b1;
					end
				end
				SQE_PULSE: begin
					if (cnt_reg == '0) begin
						state_reg <= SQE_IDLE;
					end else begin
						cnt_reg <= cnt_reg - 1'b1;
					end
				end
				default: begin
					state_reg <= SQE_IDLE;
				end
			endcase
		end
	end

	assign sqe.sqe_col = (state_reg == SQE_PULSE);
endmodule // tbo_sqe_gen
`default_nettype wire

//--- verilog/tbo_ops_reg.sv
// 10Base-T operations register with its monitor and control logic
// Function
// - Register sits at management address 18.
// - Remote jabber flag latches high, clears on read or reset.
// - Receive activity timed with transmit jabber limit; flag drives nothing else.
// - Polarity flag is one when receive pair is reversed.
// - Reception continues normally whatever the pair polarity.
// - Jabber inhibit bit disables the transmit jabber check.
// - Auto polarity inhibit bit stops automatic polarity correction.
// - Polarity correction completes only with automatic crossover disabled.
// - SQE inhibit bit stops SQE test pulses.
// - SQE test pulses collision shortly after transmit enable falls.
// - Full duplex or repeater mode suppresses SQE test.
// - Automatic SQE suppression never alters the stored inhibit bit.
// - Link loss inhibit forces the link state machine to pass.
// - Squelch inhibit requires valid data then idle before link.
`default_nettype none
module tbo_ops_reg
	import tbo_pkg::*;
#(
	parameter int JABBER_CYCLES = JABBER_LIMIT_CYCLES // Jabber limit in clocks
) (
	input wire logic core_clk, // 20 MHz clock
	input wire logic rst_n, // Async reset, active low
	input wire logic [4:0] mgmt_addr, // Management register address
	input wire logic mgmt_wr, // Write strobe, one cycle
	input wire logic [15:0] mgmt_wdata, // Write data
	input wire logic mgmt_rd, // Read strobe, one cycle
	output logic [15:0] mgmt_rdata, // Read data, registered
	output logic mgmt_rvalid, // Read data valid pulse
	input wire logic tx_en, // Transmit enable from MAC
	input wire logic rx_active, // Receive activity on the pair
	input wire logic rx_pol_reversed, // Front end sees pair reversed
	input wire logic rx_valid_data, // Valid 10Base-T data seen
	input wire logic rx_idle, // Idle seen after data
	input wire logic rx_link_lost, // Link test pulses missing
	input wire logic full_duplex, // Full-duplex mode
	input wire logic repeater_mode, // Repeater mode
	input wire logic mdix_auto_en, // Automatic crossover enabled
	output logic rx_pol_correct, // Invert receive data
	output logic tx_jabber, // Transmit jabber, halts transmit
	output logic link_pass, // Link integrity passed
	output logic sqe_col // SQE test collision pulse
);
	logic [SYNC_W-1:0] sync1_reg;
	logic [SYNC_W-1:0] sync2_reg;
	logic s_tx_en, s_rx_active, s_pol, s_valid, s_idle, s_lost, s_fdx, s_rep, s_mdix;
	logic [15:0] ctrl_reg;
	logic rjab_reg;
	logic pol_reg;
	logic [31:0] rx_cnt_reg;
	logic [31:0] tx_cnt_reg;
	logic rx_jab_event;
	logic sel, rd_hit, wr_hit;
	logic [15:0] rd_value;
	tbo_link_state_type link_reg;
	tbo_link_state_type link_next;
	tbo_sqe_if sqe_bus ();

	function automatic logic [31:0] bump(input logic active, input logic [31:0] cnt);
		bump = active ? ((cnt == 32'hffff_ffff) ? cnt : cnt + 32'h1) : 32'h0;
	endfunction

	// All front-end and MAC levels arrive from other timing domains
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			sync1_reg <= '0;
			sync2_reg <= '0;
		end else begin
			sync1_reg <= {mdix_auto_en, repeater_mode, full_duplex, rx_link_lost,
				rx_idle, rx_valid_data, rx_pol_reversed, rx_active};
			sync2_reg <= sync1_reg;
		end
	end
	assign {s_mdix, s_rep, s_fdx, s_lost, s_idle, s_valid, s_pol, s_rx_active} = sync2_reg;

	logic txs1_reg, txs2_reg;
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			txs1_reg <= 1'b0;
			txs2_reg <= 1'b0;
		end else begin
			txs1_reg <= tx_en;
			txs2_reg <= txs1_reg;
		end
	end
	assign s_tx_en = txs2_reg;

	assign sel = (mgmt_addr == TBO_REG_ADDR);
	assign rd_hit = sel & mgmt_rd;
	assign wr_hit = sel & mgmt_wr;

	// Reserved bits are stored as written; the manager keeps defaults there
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_reg <= TBO_RESET_VALUE;
		end else if (wr_hit) begin
			ctrl_reg <= mgmt_wdata & TBO_RW_MASK;
		end
	end

	// Receive jabber uses the transmit criterion: activity past the limit
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			rx_cnt_reg <= '0;
		end else begin
			rx_cnt_reg <= bump(s_rx_active, rx_cnt_reg);
		end
	end
	assign rx_jab_event = s_rx_active && (rx_cnt_reg == 32'(JABBER_CYCLES - 1));

	// Set wins over the clear of a simultaneous read
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			rjab_reg <= 1'b0;
		end else if (rx_jab_event) begin
			rjab_reg <= 1'b1;
		end else if (rd_hit) begin
			rjab_reg <= 1'b0;
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			pol_reg <= 1'b0;
		end else if (s_pol) begin
			pol_reg <= 1'b1;
		end else if (rd_hit) begin
			pol_reg <= 1'b0;
		end
	end

	// Automatic crossover cannot settle on an inverted pair, so correct only without it
	assign rx_pol_correct = s_pol & ~ctrl_reg[BIT_AUTOPOL_INH]
		& ~s_mdix;

	// Transmit jabber holds until transmit enable drops or the jabber inhibit bit is set
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			tx_cnt_reg <= '0;
		end else begin
			tx_cnt_reg <= bump(s_tx_en, tx_cnt_reg);
		end
	end
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			tx_jabber <= 1'b0;
		end else if (ctrl_reg[BIT_JABBER_INH] || !s_tx_en) begin
			tx_jabber <= 1'b0;
		end else if (tx_cnt_reg >= 32'(JABBER_CYCLES - 1)) begin
			tx_jabber <= 1'b1;
		end
	end

	// Link integrity
	always_comb begin
		link_next = link_reg;
		case (link_reg)
			LINK_FAIL: begin
				if (s_valid) begin
					link_next = ctrl_reg[BIT_SQUELCH_INH] ? LINK_WAIT_IDLE : LINK_PASS;
				end
			end
			LINK_WAIT_IDLE: begin
				if (s_lost) begin
					link_next = LINK_FAIL;
				end else if (s_idle) begin
					link_next = LINK_PASS;
				end
			end
			LINK_PASS: begin
				if (s_lost) begin
					link_next = LINK_FAIL;
				end
			end
			default: begin
				link_next = LINK_FAIL;
			end
		endcase
		if (ctrl_reg[BIT_LINKLOSS_INH]) begin
			link_next = LINK_PASS;
		end
	end
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			link_reg <= LINK_FAIL;
		end else begin
			link_reg <= link_next;
		end
	end
	assign link_pass = (link_reg == LINK_PASS);

	// Suppression is applied here only; the stored inhibit bit is untouched
	assign sqe_bus.tx_en = s_tx_en;
	assign sqe_bus.sqe_enable = ~ctrl_reg[BIT_SQE_INH]
		& ~s_fdx & ~s_rep;
	assign sqe_col = sqe_bus.sqe_col;

	tbo_sqe_gen u_sqe (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.sqe(sqe_bus.gen)
	);

	always_comb begin
		rd_value = ctrl_reg;
		rd_value[BIT_REMOTE_JABBER] = rjab_reg;
		rd_value[BIT_POL_REVERSED] = pol_reg;
	end

	// Unmapped addresses read as zero with a valid pulse
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			mgmt_rdata <= TBO_ZERO;
			mgmt_rvalid <= 1'b0;
		end else begin
			mgmt_rvalid <= mgmt_rd;
			if (mgmt_rd) begin
				mgmt_rdata <= sel ? rd_value : TBO_ZERO;
			end
		end
	end
endmodule // tbo_ops_reg
`default_nettype wire

//--- dv/tbo_ops_monitor.sv
// Port checker for the 10Base-T operations register
`default_nettype none
module tbo_ops_monitor
	import tbo_pkg::*;
#(
	parameter int JABBER_CYCLES = 50 // Jabber limit
) (
	input wire logic core_clk, // Clock
	input wire logic rst_n, // Reset
	input wire logic [4:0] mgmt_addr, // Address
	input wire logic mgmt_wr, // Write
	input wire logic [15:0] mgmt_wdata, // Write data
	input wire logic mgmt_rd, // Read
	input wire logic [15:0] mgmt_rdata, // Read data
	input wire logic mgmt_rvalid, // Read valid
	input wire logic tx_en, // Transmit
	input wire logic rx_pol_reversed, // Reversed
	input wire logic full_duplex, // Duplex
	input wire logic repeater_mode, // Repeater
	input wire logic mdix_auto_en, // Crossover
	input wire logic rx_pol_correct, // Fix
	input wire logic tx_jabber, // Jabber
	input wire logic link_pass, // Link
	input wire logic sqe_col // SQE
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	sequence sqe_hold;
		sqe_col [*8];
	endsequence
	sequence reg_write(int b);
		mgmt_wr && mgmt_addr == TBO_REG_ADDR && mgmt_wdata[b];
	endsequence
	read_answered_a: assert property (mgmt_rd |=> mgmt_rvalid)
		else $error("read not answered");
	answer_only_a: assert property (mgmt_rvalid |-> $past(mgmt_rd))
		else $error("answer without read");
	unmapped_zero_a: assert property (mgmt_rd && mgmt_addr != TBO_REG_ADDR |=>
		mgmt_rdata == TBO_ZERO) else $error("unmapped read not zero");
	polarity_fix_a: assert property (rx_pol_correct |->
		$past(rx_pol_reversed, 2) && !$past(mdix_auto_en, 2)) else $error("bad correction");
	sqe_width_a: assert property ($rose(sqe_col) |-> sqe_hold)
		else $error("sqe pulse short");
	sqe_after_tx_a: assert property ($rose(sqe_col) |-> !$past(tx_en, 16))
		else $error("sqe pulse too early");
	sqe_mode_off_a: assert property (sqe_col |->
		!$past(full_duplex, 3) && !$past(repeater_mode, 3)) else $error("sqe in mode");
	link_forced_a: assert property (reg_write(BIT_LINKLOSS_INH) |-> ##3 link_pass)
		else $error("link not forced");
	jabber_off_a: assert property (reg_write(BIT_JABBER_INH) |-> ##3 !tx_jabber)
		else $error("jabber not inhibited");
endmodule // tbo_ops_monitor
bind tbo_ops_reg tbo_ops_monitor #(.JABBER_CYCLES(JABBER_CYCLES)) tbo_ops_monitor_inst (
	.core_clk(core_clk),
	.rst_n(rst_n),
	.mgmt_addr(mgmt_addr),
	.mgmt_wr(mgmt_wr),
	.mgmt_wdata(mgmt_wdata),
	.mgmt_rd(mgmt_rd),
	.mgmt_rdata(mgmt_rdata),
	.mgmt_rvalid(mgmt_rvalid),
	.tx_en(tx_en),
	.rx_pol_reversed(rx_pol_reversed),
	.full_duplex(full_duplex),
	.repeater_mode(repeater_mode),
	.mdix_auto_en(mdix_auto_en),
	.rx_pol_correct(rx_pol_correct),
	.tx_jabber(tx_jabber),
	.link_pass(link_pass),
	.sqe_col(sqe_col)
);
`default_nettype wire

//--- dv/tbo_sta_model.sv
// Station management model issuing register accesses
`default_nettype none
module tbo_sta_model
	import tbo_pkg::*;
(
	input wire logic core_clk, // Clock
	output logic [4:0] mgmt_addr, // Address
	output logic mgmt_wr, // Write
	output logic [15:0] mgmt_wdata, // Write data
	output logic mgmt_rd, // Read
	input wire logic [15:0] mgmt_rdata, // Read data
	input wire logic mgmt_rvalid // Read valid
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		mgmt_addr = TBO_REG_ADDR;
		mgmt_wr = 1'b0;
		mgmt_wdata = TBO_ZERO;
		mgmt_rd = 1'b0;
	end
	task automatic wr(input logic [4:0] a, input logic [15:0] d);
		@(posedge core_clk);
		#5;
		mgmt_addr = a;
		mgmt_wdata = (d & ~16'h3fd0) | 16'h0010;
		mgmt_wr = 1'b1;
		@(posedge core_clk);
		#5;
		mgmt_wr = 1'b0;
		mgmt_wdata = ~mgmt_wdata;
	endtask
	task automatic rd(input logic [4:0] a, output logic [15:0] d);
		@(posedge core_clk);
		#5;
		mgmt_addr = a;
		mgmt_rd = 1'b1;
		@(posedge core_clk);
		#5;
		mgmt_rd = 1'b0;
		d = mgmt_rvalid ? mgmt_rdata : 16'hdead;
	endtask
endmodule // tbo_sta_model
`default_nettype wire

//--- dv/test_tbo_ops_reg.sv
// Self-checking bench for the 10Base-T operations register
`default_nettype none
module test_tbo_ops_reg;
	import tbo_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	logic core_clk, rst_n, mgmt_wr, mgmt_rd, mgmt_rvalid, tx_en, rx_active, rx_pol_reversed;
	logic rx_valid_data, rx_idle, rx_link_lost, full_duplex, repeater_mode, mdix_auto_en;
	logic rx_pol_correct, tx_jabber, link_pass, sqe_col, seen;
	logic [4:0] mgmt_addr;
	logic [15:0] mgmt_wdata, mgmt_rdata, d;
	int failures = 0;
	int n_compared = 0;
	int cycles = 0;
	tbo_ops_reg #(.JABBER_CYCLES(50)) tbo_ops_reg_inst (.*);
	tbo_sta_model tbo_sta_model_inst (.*);
	always #25 core_clk = ~core_clk;
	task automatic step(input int n);
		repeat (n) @(posedge core_clk);
		#5;
	endtask
	task automatic chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
		n_compared++;
		if (got !== exp) begin
			failures++;
			$display("[ERR] %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic rc(input logic [15:0] e);
		logic [15:0] v;
		tbo_sta_model_inst.rd(TBO_REG_ADDR, v);
		chk("reg", v, e);
	endtask
	task automatic give_verdict;
		$display("compared %0d failures %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	always @(posedge core_clk) begin
		cycles++;
		if (cycles == 20000) begin
			failures++;
			give_verdict();
		end
	end
	initial begin
		core_clk = 1'b0;
		rst_n = 1'b0;
		{tx_en, rx_active, rx_pol_reversed, rx_valid_data, rx_idle} = '0;
		{rx_link_lost, full_duplex, repeater_mode, mdix_auto_en} = '0;
		step(5);
		rst_n = 1'b1;
		rc(16'h0010);
		tbo_sta_model_inst.rd(5'h11, d);
		chk("unmapped", d, TBO_ZERO);
		tbo_sta_model_inst.wr(TBO_REG_ADDR, 16'hc02f);
		rc(16'h003f);
		tbo_sta_model_inst.wr(TBO_REG_ADDR, 16'h0010);
		$display("done: access");
		rx_pol_reversed = 1'b1;
		step(4);
		chk("polfix", 16'(rx_pol_correct), 16'h0001);
		tbo_sta_model_inst.wr(TBO_REG_ADDR, 16'h0018);
		step(2);
		chk("polfix", 16'(rx_pol_correct), 16'h0000);
		rx_pol_reversed = 1'b0;
		step(4);
		rc(16'h4018);
		rc(16'h0018);
		tbo_sta_model_inst.wr(TBO_REG_ADDR, 16'h0010);
		rx_pol_reversed = 1'b1;
		mdix_auto_en = 1'b1;
		step(4);
		chk("polfix", 16'(rx_pol_correct), 16'h0000);
		rx_pol_reversed = 1'b0;
		mdix_auto_en = 1'b0;
		// Drain the synchroniser, else a late set beats the read-clear
		step(3);
		rc(16'h4010);
		$display("done: polarity");
		rx_active = 1'b1;
		step(60);
		chk("txjab", 16'(tx_jabber), 16'h0000);
		rx_active = 1'b0;
		step(4);
		rc(16'h8010);
		rc(16'h0010);
		tx_en = 1'b1;
		step(60);
		chk("txjab", 16'(tx_jabber), 16'h0001);
		tbo_sta_model_inst.wr(TBO_REG_ADDR, 16'h0030);
		step(2);
		chk("txjab", 16'(tx_jabber), 16'h0000);
		tx_en = 1'b0;
		step(60);
		tbo_sta_model_inst.wr(TBO_REG_ADDR, 16'h0010);
		$display("done: jabber");
		for (int i = 0; i < 4; i++) begin
			tbo_sta_model_inst.wr(TBO_REG_ADDR, (i == 1) ? 16'h0014 : 16'h0010);
			full_duplex = (i == 2);
			repeater_mode = (i == 3);
			step(3);
			tx_en = 1'b1;
			step(10);
			tx_en = 1'b0;
			seen = 1'b0;
			repeat (60) begin
				step(1);
				seen = seen | sqe_col;
			end
			chk("sqe", 16'(seen), 16'(i == 0));
			rc((i == 1) ? 16'h0014 : 16'h0010);
		end
		full_duplex = 1'b0;
		repeater_mode = 1'b0;
		$display("done: sqe");
		rx_link_lost = 1'b1;
		step(4);
		chk("link", 16'(link_pass), 16'h0000);
		rx_link_lost = 1'b0;
		rx_valid_data = 1'b1;
		step(4);
		chk("link", 16'(link_pass), 16'h0001);
		rx_valid_data = 1'b0;
		rx_link_lost = 1'b1;
		step(4);
		rx_link_lost = 1'b0;
		tbo_sta_model_inst.wr(TBO_REG_ADDR, 16'h0011);
		rx_valid_data = 1'b1;
		step(4);
		chk("link", 16'(link_pass), 16'h0000);
		rx_idle = 1'b1;
		step(4);
		chk("link", 16'(link_pass), 16'h0001);
		rx_idle = 1'b0;
		rx_valid_data = 1'b0;
		tbo_sta_model_inst.wr(TBO_REG_ADDR, 16'h0012);
		rx_link_lost = 1'b1;
		step(4);
		chk("link", 16'(link_pass), 16'h0001);
		$display("done: link");
		// Latch a flag, then a mid-run reset must clear it and the forced link
		rx_pol_reversed = 1'b1;
		step(4);
		rx_pol_reversed = 1'b0;
		step(3);
		rst_n = 1'b0;
		step(2);
		rst_n = 1'b1;
		rc(16'h0010);
		chk("link", 16'(link_pass), 16'h0000);
		$display("done: reset");
		give_verdict();
	end
endmodule // test_tbo_ops_reg
`default_nettype wire
